// >>> pll_base_clock_selector.sv
// base clock selector: register file, interlocks, glitch-free switch, divide by two
// Operation
// - zero multiplier acts as one
// - zero range keeps PLL off, refuses VCO
// - zero range forces crystal source
// - switch waits three crystal edges, and three VCO edges while PLL enabled
// - output static during a switch
// - selected source divided by two
// - select bit picks crystal or VCO
// - no VCO select while PLL off
// - no PLL off while VCO selected
// - power and select change need separate writes
// - PLL follows enable input
// - run-in-stop keeps oscillator running
// - otherwise oscillator follows enable input
// - base clock 50 percent duty
// - interrupt driven from lock detector
// - lock toggle raises interrupt in auto
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps

module pll_base_clock_selector (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // clocks and analog status
    input  wire logic        crystal_clock,
    input  wire logic        vco_clock,
    input  wire logic        pll_locked,
    input  wire logic        pll_tracking,
    input  wire logic        osc_enable_from_sysint,
    input  wire logic        osc_run_in_stop,
    // outputs
    output logic             base_clock_out,
    output logic             osc_enable,
    output logic             pll_enable,
    output logic             filter_track,
    output logic      [11:0] vco_multiplier,
    output logic      [7:0]  vco_range,
    output logic      [1:0]  range_power,
    output logic             pll_lock_irq
);
    // two states one bit apart; no code is left unused
    typedef enum logic {
        SW_RUN  = 1'b0,
        SW_HOLD = 1'b1
    } switch_state_t;

    // whole block state; one copy computed, one registered
    typedef struct packed {
        logic          ack;
        logic [31:0]   rdata;
        logic          irq_en;
        logic          flag;
        logic          power;
        logic          select;
        logic [1:0]    rpow;
        logic          auto_bw;
        logic          acq;
        logic [11:0]   mult;
        logic [7:0]    vrange;
        logic          lock_prev;
        switch_state_t sw;
        logic          src_vco;
        logic [1:0]    xcnt;
        logic [1:0]    vcnt;
        logic          base;
        logic          osc_en;
        logic          pll_en;
        logic          track;
        logic [11:0]   mult_eff;
        logic          irq;
    } sel_state_t;

    sel_state_t s_q;
    sel_state_t s_d;

    logic [1:0]                     rst_sync_q;
    logic                           rst_n;
    logic [clksel_pkg::SY_N-1:0]    sy_in;
    logic [clksel_pkg::SY_N-1:0]    sy_lvl;
    logic [clksel_pkg::SY_N-1:0]    sy_rise;

    // the two-bit edge counters must be able to reach a nonzero switch count
    if (clksel_pkg::SWITCH_EDGES == 2'h0) begin : g_bad_edges
        $error("switch edge count must be at least one");
    end

    // reset release through two flops; assertion stays immediate,
    // release is clocked so no flop leaves reset on a different edge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // every pin from outside the domain is synchronised; the source
    // clocks are sampled as data, so each must stay below half of
    // ref_clk or a synced rise can be lost
    assign sy_in[clksel_pkg::SY_XTAL] = crystal_clock;
    assign sy_in[clksel_pkg::SY_VCO]  = vco_clock;
    assign sy_in[clksel_pkg::SY_LOCK] = pll_locked;
    assign sy_in[clksel_pkg::SY_ACQ]  = pll_tracking;
    assign sy_in[clksel_pkg::SY_OSC]  = osc_enable_from_sysint;
    assign sy_in[clksel_pkg::SY_STOP] = osc_run_in_stop;

    clk_edge_sync #(
        .WIDTH (clksel_pkg::SY_N)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (sy_in),
        .level    (sy_lvl),
        .rise     (sy_rise)
    );

    always_comb begin
        // working values, each given a value first
        logic       req;
        logic       wr;
        logic       rd;
        logic [7:0] idx;
        logic [7:0] d;
        logic       range_ok;
        logic       pwr_chg;
        logic       sel_chg;
        logic       lock_tog;
        logic       want_vco;
        logic       osc_on;
        req      = 1'b0;
        wr       = 1'b0;
        rd       = 1'b0;
        idx      = 8'h00;
        d        = 8'h00;
        range_ok = 1'b0;
        pwr_chg  = 1'b0;
        sel_chg  = 1'b0;
        lock_tog = 1'b0;
        want_vco = 1'b0;
        osc_on   = 1'b0;
        s_d      = s_q;

        // bus decode; one-cycle ack, dropped the cycle after
        // a request still held while ack is high is not taken twice,
        // so a master drops cyc and stb for a cycle between transfers
        req      = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wr       = req & wb_we_i & wb_sel_i[0];
        rd       = req & ~wb_we_i;
        idx      = {2'h0, wb_adr_i[7:2]};
        d        = wb_dat_i[7:0];
        s_d.ack  = req;
        range_ok = (s_q.vrange != 8'h00);

        // register writes with their interlocks; a refused field is
        // dropped silently, the transfer is still acknowledged
        // power and select changed in one write leave both untouched,
        // the rest of the control byte still lands
        if (wr) begin
            unique case (idx)
                clksel_pkg::IDX_CTRL: begin
                    s_d.irq_en = s_q.auto_bw & d[clksel_pkg::CTRL_IRQ_EN_BIT];
                    pwr_chg = d[clksel_pkg::CTRL_POWER_BIT] != s_q.power;
                    sel_chg = d[clksel_pkg::CTRL_SELECT_BIT] != s_q.select;
                    if (!(pwr_chg && sel_chg)) begin
                        if (pwr_chg && !(s_q.select && !d[clksel_pkg::CTRL_POWER_BIT])) begin
                            s_d.power = d[clksel_pkg::CTRL_POWER_BIT];
                        end
                        if (sel_chg && s_q.power && range_ok) begin
                            s_d.select = d[clksel_pkg::CTRL_SELECT_BIT];
                        end
                    end
                    if (!s_q.power) begin
                        s_d.rpow = d[1:0];
                    end
                end
                // acq is writable only in manual mode
                clksel_pkg::IDX_BANDWIDTH: begin
                    s_d.auto_bw = d[clksel_pkg::BW_AUTO_BIT];
                    if (!s_q.auto_bw) begin
                        s_d.acq = d[clksel_pkg::BW_ACQ_BIT];
                    end
                end
                // multiplier and range fields freeze while the power bit is set
                clksel_pkg::IDX_MULT_HIGH: begin
                    if (!s_q.power) begin
                        s_d.mult[11:8] = d[3:0];
                    end
                end
                clksel_pkg::IDX_MULT_LOW: begin
                    if (!s_q.power) begin
                        s_d.mult[7:0] = d;
                    end
                end
                clksel_pkg::IDX_VCO_RANGE: begin
                    if (!s_q.power) begin
                        s_d.vrange = d;
                    end
                end
                default: begin
                end
            endcase
        end
        // interrupt enable is forced clear in manual mode
        // manual mode has no lock indication to raise it
        if (!s_d.auto_bw) begin
            s_d.irq_en = 1'b0;
        end
        // select forced clear when PLL off or range zero
        // keeps a stale select from naming a VCO stopped by power off or a zero range
        s_d.select = s_d.select & s_d.power & (s_d.vrange != 8'h00);

        // read data; unmapped reads return zero
        // read data stands until the next read
        if (rd) begin
            s_d.rdata = 32'h0000_0000;
            unique case (idx)
                clksel_pkg::IDX_CTRL: begin
                    s_d.rdata[7:0] = {s_q.irq_en, s_q.flag & s_q.auto_bw, s_q.power,
                                      s_q.select, 2'h0, s_q.rpow};
                end
                clksel_pkg::IDX_BANDWIDTH: begin
                    s_d.rdata[7:0] = {s_q.auto_bw, sy_lvl[clksel_pkg::SY_LOCK] & s_q.auto_bw,
                                      s_q.track, 5'h00};
                end
                clksel_pkg::IDX_MULT_HIGH: begin
                    s_d.rdata[7:0] = {4'h0, s_q.mult[11:8]};
                end
                clksel_pkg::IDX_MULT_LOW: begin
                    s_d.rdata[7:0] = s_q.mult[7:0];
                end
                clksel_pkg::IDX_VCO_RANGE: begin
                    s_d.rdata[7:0] = s_q.vrange;
                end
                default: begin
                end
            endcase
        end

        // lock toggle sets the flag; a set beats a read clear
        // so a lock change landing on the clearing read is not lost
        s_d.lock_prev = sy_lvl[clksel_pkg::SY_LOCK];
        lock_tog = (sy_lvl[clksel_pkg::SY_LOCK] != s_q.lock_prev) & s_q.auto_bw;
        if (rd && idx == clksel_pkg::IDX_CTRL) begin
            s_d.flag = 1'b0;
        end
        if (lock_tog) begin
            s_d.flag = 1'b1;
        end
        if (!s_q.auto_bw) begin
            s_d.flag = 1'b0;
        end
        s_d.irq = s_q.flag & s_q.irq_en & s_q.auto_bw;

        // oscillator and PLL enables
        // run-in-stop overrides the stop request for the crystal only;
        // the PLL still follows the enable input
        osc_on     = sy_lvl[clksel_pkg::SY_OSC] | sy_lvl[clksel_pkg::SY_STOP];
        s_d.osc_en = osc_on;
        s_d.pll_en = sy_lvl[clksel_pkg::SY_OSC] & s_q.power & range_ok;
        s_d.track  = s_q.auto_bw ? sy_lvl[clksel_pkg::SY_ACQ] : s_q.acq;
        s_d.mult_eff = (s_q.mult == 12'h000) ? 12'h001 : s_q.mult;

        // glitch-free source switch, output held while waiting
        // the output only toggles on a synced rise of the source in use,
        // so every level lasts at least one source half period; a
        // selection that flips back during the hold ends on the old source
        want_vco = s_q.select & s_q.power & range_ok;
        unique case (s_q.sw)
            SW_RUN: begin
                // a new selection freezes the output before any source edge
                if (want_vco != s_q.src_vco) begin
                    s_d.sw   = SW_HOLD;
                    s_d.xcnt = 2'h0;
                    s_d.vcnt = 2'h0;
                end else if (s_q.src_vco ? sy_rise[clksel_pkg::SY_VCO]
                                         : sy_rise[clksel_pkg::SY_XTAL]) begin
                    s_d.base = ~s_q.base;
                end
            end
            SW_HOLD: begin
                // count edges of both sources; counters saturate
                if (sy_rise[clksel_pkg::SY_XTAL] && s_q.xcnt != clksel_pkg::SWITCH_EDGES) begin
                    s_d.xcnt = s_q.xcnt + 2'h1;
                end
                if (sy_rise[clksel_pkg::SY_VCO] && s_q.vcnt != clksel_pkg::SWITCH_EDGES) begin
                    s_d.vcnt = s_q.vcnt + 2'h1;
                end
                // a stopped VCO cannot deliver its edges
                // so with the PLL off the switch waits on the crystal count only
                if (s_q.xcnt == clksel_pkg::SWITCH_EDGES &&
                    (s_q.vcnt == clksel_pkg::SWITCH_EDGES || !s_q.pll_en)) begin
                    s_d.sw      = SW_RUN;
                    s_d.src_vco = want_vco;
                end
            end
        endcase
    end

    // all state but the reset and input synchronisers registered in one place
    // reset values come from the package; the rest of the state is zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q           <= '0;
            s_q.power     <= clksel_pkg::RST_POWER;
            s_q.rpow      <= clksel_pkg::RST_RANGE_POW;
            s_q.mult      <= clksel_pkg::RST_MULT;
            s_q.vrange    <= clksel_pkg::RST_VCO_RANGE;
            s_q.mult_eff  <= clksel_pkg::RST_MULT;
            s_q.sw        <= SW_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    // no output passes through gates, so none can glitch
    assign wb_ack_o       = s_q.ack;
    assign wb_dat_o       = s_q.rdata;
    assign base_clock_out = s_q.base;
    assign osc_enable     = s_q.osc_en;
    assign pll_enable     = s_q.pll_en;
    assign filter_track   = s_q.track;
    assign vco_multiplier = s_q.mult_eff;
    assign vco_range      = s_q.vrange;
    assign range_power    = s_q.rpow;
    assign pll_lock_irq   = s_q.irq;
endmodule

// >>> clk_edge_sync.sv
// package of shared constants, and a two-flop synchroniser with rise detect
`timescale 1ns/1ps

package clksel_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_CTRL      = 8'h36;
    localparam logic [7:0] IDX_BANDWIDTH = 8'h37;
    localparam logic [7:0] IDX_MULT_HIGH = 8'h38;
    localparam logic [7:0] IDX_MULT_LOW  = 8'h39;
    localparam logic [7:0] IDX_VCO_RANGE = 8'h3a;
    // control register field positions
    localparam int CTRL_IRQ_EN_BIT  = 7;
    localparam int CTRL_FLAG_BIT    = 6;
    localparam int CTRL_POWER_BIT   = 5;
    localparam int CTRL_SELECT_BIT  = 4;
    // bandwidth register field positions
    localparam int BW_AUTO_BIT      = 7;
    localparam int BW_LOCK_BIT      = 6;
    localparam int BW_ACQ_BIT       = 5;
    // values after reset
    localparam logic        RST_POWER      = 1'b1;
    localparam logic [1:0]  RST_RANGE_POW  = 2'h0;
    localparam logic [11:0] RST_MULT       = 12'h040;
    localparam logic [7:0]  RST_VCO_RANGE  = 8'h40;
    // source edges to wait on a switch
    localparam logic [1:0]  SWITCH_EDGES   = 2'h3;
    // bit positions in the synchroniser bank
    localparam int SY_XTAL = 0;
    localparam int SY_VCO  = 1;
    localparam int SY_LOCK = 2;
    localparam int SY_ACQ  = 3;
    localparam int SY_OSC  = 4;
    localparam int SY_STOP = 5;
    localparam int SY_N    = 6;
endpackage

module clk_edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    // refuse an empty bank at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("clk_edge_sync: WIDTH must be at least one");
    end

    // shift chain; first stage feeds only the second
    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // per-bit level and rising edge
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign level[i] = s_q.sync[i];
        assign rise[i]  = s_q.sync[i] & ~s_q.prev[i];
    end
endmodule

// >>> pll_base_clock_selector_monitor.sv
// assertions on the base clock selector ports
`timescale 1ns/1ps
module pll_base_clock_selector_monitor (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        osc_enable_from_sysint,
    input wire logic        osc_run_in_stop,
    input wire logic        base_clock_out,
    input wire logic        osc_enable,
    input wire logic        pll_enable,
    input wire logic [11:0] vco_multiplier,
    input wire logic [7:0]  vco_range
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // bus answer shape
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rd_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits not zero");
    // programming exceptions
    property p_mult; vco_multiplier != 12'h000; endproperty
    a_mult: assert property (p_mult) else $error("multiplier shown as zero");
    property p_range_off; vco_range == 8'h00 |-> !pll_enable; endproperty
    a_range_off: assert property (p_range_off) else $error("pll on with zero range");
    // oscillator and pll gating
    property p_osc_on; (osc_enable_from_sysint | osc_run_in_stop) [*8] |=> osc_enable; endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator not running");
    property p_osc_off; !(osc_enable_from_sysint | osc_run_in_stop) [*8] |=> !osc_enable;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator not stopped");
    property p_pll_osc; !osc_enable_from_sysint [*8] |=> !pll_enable; endproperty
    a_pll_osc: assert property (p_pll_osc) else $error("pll on without enable");
    // each base clock level lasts several cycles
    sequence s_hold; $stable(base_clock_out) [*3]; endsequence
    property p_no_short; $changed(base_clock_out) |=> s_hold; endproperty
    a_no_short: assert property (p_no_short) else $error("short base clock pulse");
endmodule
bind pll_base_clock_selector pll_base_clock_selector_monitor i_pll_base_clock_selector_monitor (
    .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .osc_enable_from_sysint(osc_enable_from_sysint),
    .osc_run_in_stop(osc_run_in_stop), .base_clock_out(base_clock_out),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .vco_multiplier(vco_multiplier),
    .vco_range(vco_range));

// >>> sysint_model.sv
// far side: source clocks and a consumer counting base clock periods
`timescale 1ns/1ps
module sysint_model (
    input  wire logic osc_enable,
    input  wire logic pll_enable,
    input  wire logic base_clock_out,
    output logic      crystal_clock,
    output logic      vco_clock,
    output int        rises
);
    // crystal stands still while the oscillator is off
    initial crystal_clock = 1'b0;
    always #40 if (osc_enable) crystal_clock = ~crystal_clock;
    // vco stands still while the pll is off
    initial vco_clock = 1'b0;
    always #20 if (pll_enable) vco_clock = ~vco_clock;
    // consumer counts base clock periods
    initial rises = 0;
    always @(posedge base_clock_out) rises = rises + 1;
endmodule

// >>> tb_pll_base_clock_selector.sv
// self-checking bench for the base clock selector
`timescale 1ns/1ps
module tb_pll_base_clock_selector;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, b;
    logic [7:0]  wb_adr_i = 8'h00, vco_range, rd;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, crystal_clock, vco_clock, base_clock_out, osc_enable;
    logic        pll_enable, filter_track, pll_lock_irq;
    logic        pll_locked = 1'b0, osc_enable_from_sysint = 1'b1, osc_run_in_stop = 1'b0;
    logic        pll_tracking = 1'b0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [11:0] vco_multiplier;
    logic [1:0]  range_power;
    int          n_fail = 0, cmp_count = 0, rises, r0;
    // rows: write flag, byte address, write data, expected read back
    logic [27:0] rows [20] = '{28'h0_d8_00_20, 28'h0_dc_00_00, 28'h0_e0_00_00,
        28'h0_e4_00_40, 28'h0_e8_00_40, 28'h1_e4_00_40, 28'h1_d8_00_00, 28'h1_e4_00_00,
        28'h1_d8_12_02, 28'h1_d8_30_00, 28'h1_d8_20_20, 28'h1_d8_30_30, 28'h1_d8_10_30,
        28'h1_d8_00_30, 28'h1_fc_ff_00, 28'h1_d8_20_20, 28'h1_d8_00_00, 28'h1_e8_00_00,
        28'h1_d8_20_20, 28'h1_d8_30_20};
    always #5 ref_clk = ~ref_clk;
    pll_base_clock_selector i_pll_base_clock_selector (
        .ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_clock(crystal_clock),
        .vco_clock(vco_clock), .pll_locked(pll_locked), .pll_tracking(pll_tracking),
        .osc_enable_from_sysint(osc_enable_from_sysint), .osc_run_in_stop(osc_run_in_stop),
        .base_clock_out(base_clock_out), .osc_enable(osc_enable), .pll_enable(pll_enable),
        .filter_track(filter_track), .vco_multiplier(vco_multiplier),
        .vco_range(vco_range), .range_power(range_power), .pll_lock_irq(pll_lock_irq));
    sysint_model i_sysint_model (
        .osc_enable(osc_enable), .pll_enable(pll_enable), .base_clock_out(base_clock_out),
        .crystal_clock(crystal_clock), .vco_clock(vco_clock), .rises(rises));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
        chk("ack", 1'b1, wb_ack_o);
        if (wb_ack_o !== 1'b1) end_of_test();
        @(posedge ref_clk);
    endtask
    // base clock periods in 1600 ns
    task automatic rate(input int lo, input int hi);
        r0 = rises;
        #1600;
        chk("base rate", 1'b1, 1'(rises - r0 >= lo && rises - r0 <= hi));
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        chk("reset mult", 12'h040, vco_multiplier);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        foreach (rows[i]) begin
            if (rows[i][24]) wb(1'b1, rows[i][23:16], rows[i][15:8]);
            wb(1'b0, rows[i][23:16], 8'h00);
            chk("read back", rows[i][7:0], rd);
        end
        $display("register rows done");
        chk("zero mult", 12'h001, vco_multiplier);
        chk("pll off", 1'b0, pll_enable);
        rate(9, 11);
        wb(1'b1, 8'hd8, 8'h00);
        wb(1'b1, 8'hd8, 8'h02);
        chk("range power", 2'h2, range_power);
        wb(1'b1, 8'he0, 8'h00);
        wb(1'b1, 8'he4, 8'h02);
        chk("multiplier", 12'h002, vco_multiplier);
        wb(1'b1, 8'he8, 8'h40);
        wb(1'b1, 8'hd8, 8'h20);
        repeat (20) @(posedge ref_clk);
        wb(1'b1, 8'hd8, 8'h30);
        b = base_clock_out;
        repeat (8) begin
            @(posedge ref_clk);
            chk("stasis", b, base_clock_out);
        end
        repeat (60) @(posedge ref_clk);
        rate(19, 21);
        $display("switch done");
        wb(1'b1, 8'hdc, 8'h80);
        wb(1'b1, 8'hd8, 8'hb0);
        pll_locked <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("lock irq", 1'b1, pll_lock_irq);
        wb(1'b0, 8'hd8, 8'h00);
        chk("flag read", 8'hf0, rd);
        repeat (3) @(posedge ref_clk);
        chk("irq clear", 1'b0, pll_lock_irq);
        wb(1'b1, 8'hdc, 8'h00);
        wb(1'b0, 8'hd8, 8'h00);
        chk("manual ctrl", 8'h30, rd);
        $display("interrupt done");
        pll_tracking <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("manual track", 1'b0, filter_track);
        wb(1'b1, 8'hdc, 8'h20);
        chk("manual acq", 1'b1, filter_track);
        wb(1'b1, 8'hdc, 8'h80);
        repeat (2) @(posedge ref_clk);
        chk("auto track", 1'b1, filter_track);
        wb(1'b0, 8'hdc, 8'h00);
        chk("bandwidth read", 8'he0, rd);
        pll_tracking <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("auto track", 1'b0, filter_track);
        $display("tracking done");
        for (int i = 0; i < 4; i++) begin
            {osc_enable_from_sysint, osc_run_in_stop} <= 2'(i);
            repeat (10) @(posedge ref_clk);
            chk("osc enable", 1'(i != 0), osc_enable);
            chk("pll enable", 1'(i > 1), pll_enable);
        end
        $display("oscillator done");
        end_of_test();
    end
endmodule
